// >>> sppe_pkg.sv
// Shared constants and types for the stack pointer load, push and pop executor
package sppe_pkg;

  // ********************************
  // Opcode bytes and patterns
  // ********************************
  localparam logic [7:0] OP_LD_SP = 8'hF9;
  localparam logic [7:0] OP_PUSH_IDX = 8'hE5;
  localparam logic [7:0] OP_POP_IDX = 8'hE1;
  localparam logic [7:0] PFX_BYTE_X = 8'hDD;
  localparam logic [7:0] PFX_BYTE_Y = 8'hFD;
  localparam logic [1:0] PAIR_OP_TOP = 2'h3;
  localparam logic [3:0] PUSH_LOW_NIB = 4'h5;
  localparam logic [3:0] POP_LOW_NIB = 4'h1;

  // ********************************
  // Clock states per machine cycle
  // ********************************
  localparam int TS_W = 3;
  localparam logic [TS_W-1:0] TS_FETCH = 3'h4;
  localparam logic [TS_W-1:0] TS_LD_SP = 3'h6;
  localparam logic [TS_W-1:0] TS_PUSH_OP = 3'h5;
  localparam logic [TS_W-1:0] TS_POP_OP = 3'h4;
  localparam logic [TS_W-1:0] TS_MEM = 3'h3;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [15:0] SP_RESET = 16'h0000;

  // ********************************
  // Types
  // ********************************
  typedef enum logic [1:0] {PFX_NONE, PFX_IDX_X, PFX_IDX_Y} sppe_prefix_type;
  typedef enum logic [2:0] {K_PREFIX, K_LD_SP, K_PUSH, K_POP, K_OTHER} sppe_kind_type;
  // Order fixes the two-bit pair_select code of the first four entries
  typedef enum logic [2:0] {
    TGT_COUNTER, TGT_DEST, TGT_POINTER, TGT_ACCF, TGT_IDX_X, TGT_IDX_Y
  } sppe_target_type;

endpackage : sppe_pkg

// >>> sppe_decode.sv
// Opcode byte decoder: operation kind, target register and machine cycle length
`timescale 1ns/1ps
module sppe_decode
(
  input logic [7:0] byte_i,
  input sppe_pkg::sppe_prefix_type prefix_i,
  output sppe_pkg::sppe_kind_type kind_o,
  output sppe_pkg::sppe_target_type target_o,
  output logic [sppe_pkg::TS_W-1:0] len_o
);

  always_comb
  begin
    kind_o = sppe_pkg::K_OTHER;
    target_o = sppe_pkg::TGT_POINTER;
    len_o = sppe_pkg::TS_FETCH;
    if (prefix_i == sppe_pkg::PFX_NONE)
    begin
      if (byte_i == sppe_pkg::PFX_BYTE_X || byte_i == sppe_pkg::PFX_BYTE_Y)
      begin
        kind_o = sppe_pkg::K_PREFIX;
        target_o = (byte_i == sppe_pkg::PFX_BYTE_X) ? sppe_pkg::TGT_IDX_X : sppe_pkg::TGT_IDX_Y;
      end
      else if (byte_i == sppe_pkg::OP_LD_SP)
      begin
        kind_o = sppe_pkg::K_LD_SP;
        len_o = sppe_pkg::TS_LD_SP;
      end
      else if (byte_i[7:6] == sppe_pkg::PAIR_OP_TOP && byte_i[3:0] == sppe_pkg::PUSH_LOW_NIB)
      begin
        kind_o = sppe_pkg::K_PUSH;
        target_o = sppe_pkg::sppe_target_type'({1'b0, byte_i[5:4]});
        len_o = sppe_pkg::TS_PUSH_OP;
      end
      else if (byte_i[7:6] == sppe_pkg::PAIR_OP_TOP && byte_i[3:0] == sppe_pkg::POP_LOW_NIB)
      begin
        kind_o = sppe_pkg::K_POP;
        target_o = sppe_pkg::sppe_target_type'({1'b0, byte_i[5:4]});
        len_o = sppe_pkg::TS_POP_OP;
      end
    end
    else
    begin
      // Prefix swaps the pointer pair for an index register
      target_o = (prefix_i == sppe_pkg::PFX_IDX_X) ? sppe_pkg::TGT_IDX_X : sppe_pkg::TGT_IDX_Y;
      if (byte_i == sppe_pkg::OP_LD_SP)
      begin
        kind_o = sppe_pkg::K_LD_SP;
        len_o = sppe_pkg::TS_LD_SP;
      end
      else if (byte_i == sppe_pkg::OP_PUSH_IDX)
      begin
        kind_o = sppe_pkg::K_PUSH;
        len_o = sppe_pkg::TS_PUSH_OP;
      end
      else if (byte_i == sppe_pkg::OP_POP_IDX)
      begin
        kind_o = sppe_pkg::K_POP;
        len_o = sppe_pkg::TS_POP_OP;
      end
    end
  end

endmodule : sppe_decode

// >>> sppe_tstate_timer.sv
// Down counter that marks the last clock state of a machine cycle
`timescale 1ns/1ps
module sppe_tstate_timer
#(
  parameter int W = 3
)
(
  input logic clk_i,
  input logic nrst_i,
  input logic load_i,
  input logic [W-1:0] len_i,
  output logic last_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } sppe_timer_type;

  sppe_timer_type t_q;
  sppe_timer_type t_d;

  if (W < 2)
  begin : g_bad_width
    $error("Timer width too small");
  end

  always_comb
  begin
    t_d = t_q;
    if (load_i)
      t_d.cnt = len_i;
    else if (t_q.cnt != '0)
      t_d.cnt = t_q.cnt - 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      t_q <= '0;
    else
      t_q <= t_d;
  end

  assign last_o = (t_q.cnt == W'(1));

endmodule : sppe_tstate_timer

// >>> sppe_exec.sv
// Stack pointer load, push and pop executor with byte-wide external memory cycles
`timescale 1ns/1ps
module sppe_exec
(
  input logic clk_i,
  input logic nrst_i,
  input logic op_valid_i,
  input logic [7:0] op_byte_i,
  output logic op_ready_o,
  input logic [15:0] counter_pair_i,
  input logic [15:0] dest_pair_i,
  input logic [15:0] pointer_pair_i,
  input logic [15:0] accum_flag_pair_i,
  input logic [15:0] index_reg_x_i,
  input logic [15:0] index_reg_y_i,
  output logic [15:0] stack_pointer_o,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  input logic [7:0] mem_rdata_i,
  output logic wb_valid_o,
  output sppe_pkg::sppe_target_type wb_sel_o,
  output logic [15:0] wb_data_o,
  output logic unsupported_o
);

  // ********************************
  // State
  // ********************************
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_WR_HI, ST_WR_LO, ST_RD_LO, ST_RD_HI} sppe_state_type;

  typedef struct packed {
    sppe_state_type st;
    sppe_pkg::sppe_prefix_type prefix;
    sppe_pkg::sppe_kind_type kind;
    sppe_pkg::sppe_target_type target;
    logic [15:0] sp;
    logic [15:0] src;
    logic [7:0] wdata;
    logic [7:0] rd_lo;
    logic rd;
    logic wr;
    logic wb_valid;
    sppe_pkg::sppe_target_type wb_sel;
    logic [15:0] wb_data;
    logic unsupported;
  } sppe_regs_type;

  sppe_regs_type r_q;
  sppe_regs_type r_d;

  sppe_pkg::sppe_kind_type dec_kind;
  sppe_pkg::sppe_target_type dec_target;
  logic [sppe_pkg::TS_W-1:0] dec_len;
  logic t_load;
  logic [sppe_pkg::TS_W-1:0] t_len;
  logic t_last;
  logic accept;
  logic [15:0] src_now;

  // Register value named by a target code
  function automatic logic [15:0] sppe_pick(input sppe_pkg::sppe_target_type tgt);
    case (tgt)
      sppe_pkg::TGT_COUNTER: sppe_pick = counter_pair_i;
      sppe_pkg::TGT_DEST: sppe_pick = dest_pair_i;
      sppe_pkg::TGT_POINTER: sppe_pick = pointer_pair_i;
      sppe_pkg::TGT_ACCF: sppe_pick = accum_flag_pair_i;
      sppe_pkg::TGT_IDX_X: sppe_pick = index_reg_x_i;
      sppe_pkg::TGT_IDX_Y: sppe_pick = index_reg_y_i;
      default: sppe_pick = pointer_pair_i;
    endcase
  endfunction : sppe_pick

  // ********************************
  // Submodules
  // ********************************
  sppe_decode u_decode
  (
    .byte_i(op_byte_i),
    .prefix_i(r_q.prefix),
    .kind_o(dec_kind),
    .target_o(dec_target),
    .len_o(dec_len)
  );

  sppe_tstate_timer #(.W(sppe_pkg::TS_W)) u_timer
  (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(t_load),
    .len_i(t_len),
    .last_o(t_last)
  );

  assign accept = op_valid_i && op_ready_o;

  // A process, not an assign, so that a change on any register input reaches the mux
  always_comb
  begin
    src_now = sppe_pick(r_q.target);
  end

  // ********************************
  // Sequencer
  // ********************************
  // The accept cycle is the first clock state of the opcode cycle, so the
  // timer is loaded with one state less than the decoded length.
  always_comb
  begin
    r_d = r_q;
    r_d.wb_valid = 1'b0;
    r_d.unsupported = 1'b0;
    t_load = 1'b0;
    t_len = sppe_pkg::TS_MEM;
    case (r_q.st)
      ST_IDLE:
      begin
        if (op_valid_i)
        begin
          r_d.kind = dec_kind;
          r_d.target = dec_target;
          r_d.st = ST_FETCH;
          t_load = 1'b1;
          t_len = dec_len - 1'b1;
        end
      end
      ST_FETCH:
      begin
        if (t_last)
        begin
          r_d.prefix = sppe_pkg::PFX_NONE;
          r_d.st = ST_IDLE;
          case (r_q.kind)
            sppe_pkg::K_PREFIX:
              r_d.prefix = (r_q.target == sppe_pkg::TGT_IDX_X) ? sppe_pkg::PFX_IDX_X : sppe_pkg::PFX_IDX_Y;
            sppe_pkg::K_LD_SP:
              r_d.sp = src_now;
            sppe_pkg::K_PUSH:
            begin
              // Source is latched here; later changes on the inputs are not seen
              r_d.src = src_now;
              r_d.sp = r_q.sp - 16'h0001;
              r_d.wdata = src_now[15:8];
              r_d.wr = 1'b1;
              r_d.st = ST_WR_HI;
              t_load = 1'b1;
            end
            sppe_pkg::K_POP:
            begin
              r_d.rd = 1'b1;
              r_d.st = ST_RD_LO;
              t_load = 1'b1;
            end
            default:
              r_d.unsupported = 1'b1;
          endcase
        end
      end
      ST_WR_HI:
      begin
        if (t_last)
        begin
          r_d.sp = r_q.sp - 16'h0001;
          r_d.wdata = r_q.src[7:0];
          r_d.st = ST_WR_LO;
          t_load = 1'b1;
        end
      end
      ST_WR_LO:
      begin
        if (t_last)
        begin
          r_d.wr = 1'b0;
          r_d.st = ST_IDLE;
        end
      end
      ST_RD_LO:
      begin
        if (t_last)
        begin
          r_d.rd_lo = mem_rdata_i;
          r_d.sp = r_q.sp + 16'h0001;
          r_d.st = ST_RD_HI;
          t_load = 1'b1;
        end
      end
      ST_RD_HI:
      begin
        if (t_last)
        begin
          r_d.rd = 1'b0;
          r_d.sp = r_q.sp + 16'h0001;
          r_d.wb_valid = 1'b1;
          r_d.wb_sel = r_q.target;
          r_d.wb_data = {mem_rdata_i, r_q.rd_lo};
          r_d.st = ST_IDLE;
        end
      end
      default:
        r_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      r_q <= '0;
      r_q.sp <= sppe_pkg::SP_RESET;
    end
    else
      r_q <= r_d;
  end

  // ********************************
  // Outputs
  // ********************************
  assign op_ready_o = (r_q.st == ST_IDLE);
  assign stack_pointer_o = r_q.sp;
  assign mem_addr_o = r_q.sp;
  assign mem_wdata_o = r_q.wdata;
  assign mem_rd_o = r_q.rd;
  assign mem_wr_o = r_q.wr;
  assign wb_valid_o = r_q.wb_valid;
  assign wb_sel_o = r_q.wb_sel;
  assign wb_data_o = r_q.wb_data;
  assign unsupported_o = r_q.unsupported;

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  logic fetch_end;
  assign fetch_end = (r_q.st == ST_FETCH) && t_last;

  // Delays count clock states from the accept cycle, or from the last opcode state where fetch_end starts the property
  a_ld_pointer_copy: assert property (
    fetch_end && r_q.kind == sppe_pkg::K_LD_SP && r_q.target == sppe_pkg::TGT_POINTER
    |=> stack_pointer_o == $past(pointer_pair_i)) else $error("Pointer pair not copied");
  a_ld_plain_time: assert property (
    accept && r_q.prefix == sppe_pkg::PFX_NONE && op_byte_i == sppe_pkg::OP_LD_SP
    |=> !op_ready_o [*5] ##1 op_ready_o) else $error("Plain load length wrong");
  a_ld_index_x: assert property (
    fetch_end && r_q.kind == sppe_pkg::K_LD_SP && r_q.target == sppe_pkg::TGT_IDX_X
    |=> stack_pointer_o == $past(index_reg_x_i)) else $error("Index x not copied");
  a_prefix_time: assert property (
    accept && r_q.prefix == sppe_pkg::PFX_NONE && op_byte_i == sppe_pkg::PFX_BYTE_X
    |=> !op_ready_o [*3] ##1 op_ready_o) else $error("Prefix cycle length wrong");
  a_ld_index_y: assert property (
    fetch_end && r_q.kind == sppe_pkg::K_LD_SP && r_q.target == sppe_pkg::TGT_IDX_Y
    |=> stack_pointer_o == $past(index_reg_y_i)) else $error("Index y not copied");
  a_push_byte_order: assert property (
    fetch_end && r_q.kind == sppe_pkg::K_PUSH
    |=> mem_wr_o && mem_wdata_o == $past(src_now[15:8])
    ##3 mem_wr_o && mem_wdata_o == $past(src_now[7:0], 4)) else $error("Push byte order wrong");
  a_push_sp_drop: assert property (
    fetch_end && r_q.kind == sppe_pkg::K_PUSH
    |-> ##6 stack_pointer_o == 16'($past(stack_pointer_o, 6) - 16'h0002)) else $error("Push pointer wrong");
  a_push_wrap_addr: assert property (
    fetch_end && r_q.kind == sppe_pkg::K_PUSH
    |-> ##4 mem_addr_o == 16'($past(stack_pointer_o, 4) - 16'h0002)) else $error("Push low byte address wrong");
  a_idx_push_time: assert property (
    accept && r_q.prefix != sppe_pkg::PFX_NONE && op_byte_i == sppe_pkg::OP_PUSH_IDX
    |-> !mem_wr_o [*5] ##1 mem_wr_o [*6] ##1 !mem_wr_o) else $error("Index push timing wrong");
  a_push_index_y: assert property (
    fetch_end && r_q.kind == sppe_pkg::K_PUSH && r_q.target == sppe_pkg::TGT_IDX_Y
    |=> mem_wdata_o == $past(index_reg_y_i[15:8]) ##3 mem_wdata_o == $past(index_reg_y_i[7:0], 4))
    else $error("Index y push bytes wrong");
  a_pop_select: assert property (
    accept && r_q.prefix == sppe_pkg::PFX_NONE && op_byte_i[7:6] == sppe_pkg::PAIR_OP_TOP
    && op_byte_i[3:0] == sppe_pkg::POP_LOW_NIB
    |-> ##10 wb_valid_o && wb_sel_o[1:0] == $past(op_byte_i[5:4], 10)) else $error("Pop target wrong");
  a_pop_bytes: assert property (
    wb_valid_o |-> wb_data_o == {$past(mem_rdata_i, 1), $past(mem_rdata_i, 4)}) else $error("Pop byte order wrong");
  a_pop_sp_rise: assert property (
    wb_valid_o |-> stack_pointer_o == 16'($past(stack_pointer_o, 7) + 16'h0002)) else $error("Pop pointer wrong");
  a_pop_index_y: assert property (
    accept && r_q.prefix == sppe_pkg::PFX_IDX_Y && op_byte_i == sppe_pkg::OP_POP_IDX
    |-> ##10 wb_valid_o && wb_sel_o == sppe_pkg::TGT_IDX_Y) else $error("Pop into index y wrong");

  c_push_index: cover property (fetch_end && r_q.kind == sppe_pkg::K_PUSH && r_q.target == sppe_pkg::TGT_IDX_Y);
  c_pop_pair: cover property (wb_valid_o && wb_sel_o == sppe_pkg::TGT_ACCF);
  c_ld_index: cover property (fetch_end && r_q.kind == sppe_pkg::K_LD_SP && r_q.target == sppe_pkg::TGT_IDX_X);
  c_ld_plain: cover property (fetch_end && r_q.kind == sppe_pkg::K_LD_SP && r_q.target == sppe_pkg::TGT_POINTER);
  c_unsupported: cover property (unsupported_o);

endmodule : sppe_exec

// >>> sppe_mem_model.sv
// Byte-wide stack memory that answers the executor's read and write cycles
`timescale 1ns/1ps
module sppe_mem_model
(
  input wire logic clk_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  output logic [7:0] mem_rdata_o
);
  // ****************
  // Storage
  // ****************
  logic [7:0] store [int];
  logic [7:0] junk_q = 8'h5A;

  // One byte stored per write cycle, no wait states
  always @(posedge clk_i)
  begin
    if (mem_wr_i)
    begin
      store[int'(mem_addr_i)] = mem_wdata_i;
    end
    junk_q <= junk_q + 8'h3B;
  end

  // Outside a read the bus shows a pattern that moves every cycle, so stale data cannot pass
  always @*
  begin
    if (mem_rd_i && store.exists(int'(mem_addr_i)))
    begin
      mem_rdata_o = store[int'(mem_addr_i)];
    end
    else
    begin
      mem_rdata_o = junk_q;
    end
  end
endmodule : sppe_mem_model

// >>> testbench.sv
// Self-checking bench for the stack pointer load, push and pop executor
`timescale 1ns/1ps
module testbench;
  logic clk_i, nrst_i, op_valid_i, op_ready_o, mem_rd_o, mem_wr_o, wb_valid_o, unsupported_o;
  logic [7:0] op_byte_i, mem_wdata_o, mem_rdata_i;
  logic [15:0] stack_pointer_o, mem_addr_o, wb_data_o;
  logic [15:0] rv [6];
  logic [31:0] sel_q, data_q;
  sppe_pkg::sppe_target_type wb_sel_o;
  int fails, tests_run, seed, sp, n;
  logic seen_wb, seen_uns;
  logic [15:0] stk [$];

  sppe_exec dut (.clk_i(clk_i), .nrst_i(nrst_i), .op_valid_i(op_valid_i), .op_byte_i(op_byte_i),
    .op_ready_o(op_ready_o), .counter_pair_i(rv[0]), .dest_pair_i(rv[1]), .pointer_pair_i(rv[2]),
    .accum_flag_pair_i(rv[3]), .index_reg_x_i(rv[4]), .index_reg_y_i(rv[5]),
    .stack_pointer_o(stack_pointer_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_rdata_i(mem_rdata_i), .wb_valid_o(wb_valid_o),
    .wb_sel_o(wb_sel_o), .wb_data_o(wb_data_o), .unsupported_o(unsupported_o));

  sppe_mem_model mem (.clk_i(clk_i), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
    .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o), .mem_rdata_o(mem_rdata_i));

  // ****************
  // Helpers
  // ****************
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Junk bytes are offered while busy; they must be refused or the timing shifts
  task automatic issue(input logic [7:0] b);
    @(posedge clk_i);
    #1;
    op_valid_i = 1'b1;
    op_byte_i = b;
    @(posedge clk_i);
    #1;
    n = 1;
    seen_wb = 1'b0;
    seen_uns = 1'b0;
    while (op_ready_o !== 1'b1)
    begin
      op_valid_i = 1'($random(seed));
      op_byte_i = 8'($random(seed));
      @(posedge clk_i);
      #1;
      n++;
      if (wb_valid_o === 1'b1)
      begin
        seen_wb = 1'b1;
        sel_q = 32'(wb_sel_o);
        data_q = 32'(wb_data_o);
      end
      if (unsupported_o === 1'b1)
        seen_uns = 1'b1;
      if (n > 40)
      begin
        fails++;
        stop_test();
      end
    end
    op_valid_i = 1'b0;
  endtask : issue

  // Push or pop of target i; 4 and 5 go through a prefix byte
  task automatic stack_op(input int i, input bit pop);
    logic [15:0] v;
    if (i >= 4)
    begin
      issue(i == 4 ? 8'hDD : 8'hFD);
      check(n, 4);
    end
    issue(i < 4 ? {2'h3, 2'(i), pop ? 4'h1 : 4'h5} : (pop ? 8'hE1 : 8'hE5));
    if (pop)
    begin
      v = stk.pop_back();
      check(n, 10);
      check(seen_wb, 1);
      check(sel_q, 32'(i));
      check(data_q, 32'(v));
      sp = (sp + 2) & 16'hFFFF;
    end
    else
    begin
      check(n, 11);
      check(mem.store[(sp - 1) & 16'hFFFF], rv[i][15:8]);
      check(mem.store[(sp - 2) & 16'hFFFF], rv[i][7:0]);
      stk.push_back(rv[i]);
      sp = (sp - 2) & 16'hFFFF;
    end
    check(stack_pointer_o, sp);
  endtask : stack_op

  // ****************
  // Stimulus
  // ****************
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial
  begin
    seed = 78;
    fails = 0;
    tests_run = 0;
    nrst_i = 1'b0;
    op_valid_i = 1'b0;
    op_byte_i = 8'h00;
    foreach (rv[i])
      rv[i] = 16'h0000;
    repeat (12) @(posedge clk_i);
    #1;
    check(stack_pointer_o, 32'h0);
    check(op_ready_o, 1);
    nrst_i = 1'b1;
    // Second round starts at 0001 so the stack wraps both ways
    for (int r = 0; r < 2; r++)
    begin
      rv[2] = (r == 0) ? 16'($random(seed)) : 16'h0001;
      issue(8'hF9);
      check(n, 6);
      sp = rv[2];
      check(stack_pointer_o, sp);
      for (int i = 0; i < 6; i++)
      begin
        rv[i] = 16'($random(seed));
        stack_op(i, 1'b0);
      end
      for (int i = 5; i >= 0; i--)
        stack_op(i, 1'b1);
    end
    for (int i = 4; i < 6; i++)
    begin
      rv[i] = 16'($random(seed));
      issue(i == 4 ? 8'hDD : 8'hFD);
      check(n, 4);
      issue(8'hF9);
      check(n, 6);
      check(stack_pointer_o, rv[i]);
    end
    issue(8'h00);
    check({seen_uns, 8'(n)}, 9'h104);
    issue(8'hDD);
    issue(8'h00);
    check(seen_uns, 1);
    issue(8'hF9);
    check(stack_pointer_o, rv[2]);
    stop_test();
  end
endmodule : testbench
